// file: hmdc_pkg.sv
// constants, field layouts and carrier types for the host memory decode block
// assumes a single 125 MHz clock domain and an Avalon-MM register slave
// Overview of operation
// RQ1: boot ROM select for C0000 to FFFFF
// RQ2: double ROM adds lower half at 40000-7FFFF
// RQ3: DRAM request on every DRAM read or write
// RQ4: row strobe is request delayed one flop
// RQ5: column strobe is pre-terminated row strobe delayed
// RQ6: column select picks address 19:10, else 9:0
// RQ7: DRAM covers bits 17-0, nine row, nine column; code muxes ten-bit halves, row 9:0 and column 19:10
// RQ8: read line low means read, else write
// RQ9: SRAM window depends on part size, map bit
// RQ10: mapped SRAM wins over upper ROM expansion space
// RQ11: software should leave the map bit clear
// RQ12: SRAM enable inverted, blocked during power down
// RQ13: card window enable for 80000 to 8FFFF
// RQ14: card address is page plus low sixteen bits
// RQ15: config bit low selects card config register
// RQ16: card buffers enabled only while bit six high
// RQ17: bus status, strobes, refresh qualify the decode
// RQ18: slave SRAM select for A0000 to A1FFF
// RQ19: DSP port select for 90000 to 97FFF
// RQ20: at most one select active at once
// RQ21: refresh cycles assert no device selects; code still raises the DRAM request on refresh at addresses up to 3FFFF
package hmdc_pkg;

   // ------------------------------------------------------------
   // register map, byte addresses on the Avalon slave
   // ------------------------------------------------------------
   localparam logic [3:0] CARD_CTRL_OFS = 4'h0;
   localparam logic [3:0] MEM_CFG_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;

   // card control fields
   localparam int PAGE_LSB = 0;
   localparam int MAP_BIT = 4;
   localparam int BUF_EN_BIT = 6;
   localparam int CFG_N_BIT = 7;
   localparam logic [7:0] CARD_CTRL_RST = 8'h80;

   // memory configuration fields
   localparam int ROM_DOUBLE_BIT = 0;
   localparam int SRAM_LARGE_BIT = 1;
   localparam logic [1:0] MEM_CFG_RST = 2'h0;

   // host bus status value meaning no bus cycle
   localparam logic [2:0] BUS_PASSIVE = 3'h7;

   // ------------------------------------------------------------
   // address windows, inclusive bounds
   // ------------------------------------------------------------
   localparam logic [19:0] ROM_LO = 20'hC0000;
   localparam logic [19:0] ROM_HI = 20'hFFFFF;
   localparam logic [19:0] ROM2_LO = 20'h40000;
   localparam logic [19:0] ROM2_HI = 20'h7FFFF;
   localparam logic [19:0] DRAM_LO = 20'h00000;
   localparam logic [19:0] DRAM_HI = 20'h3FFFF;
   localparam logic [19:0] SRAM_LO = 20'hB0000;
   localparam logic [19:0] SRAM_SMALL_HI = 20'hB7FFF;
   localparam logic [19:0] SRAM_LARGE_HI = 20'hBFFFF;
   localparam logic [19:0] SRAM_EXT_LO = 20'h70000;
   localparam logic [19:0] SRAM_EXT_HI = 20'h7FFFF;
   localparam logic [19:0] CARD_LO = 20'h80000;
   localparam logic [19:0] CARD_HI = 20'h8FFFF;
   localparam logic [19:0] DSP_LO = 20'h90000;
   localparam logic [19:0] DSP_HI = 20'h97FFF;
   localparam logic [19:0] SLAVE_LO = 20'hA0000;
   localparam logic [19:0] SLAVE_HI = 20'hA1FFF;

   // one bit per decoded region, active high
   typedef struct packed {
      logic rom;
      logic sram;
      logic card;
      logic dsp;
      logic slave;
      logic dram;
   } hmdc_sel_t;

endpackage

// file: hmdc_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are quasi-static relative to the host bus cycle
`timescale 1ns/1ps
module hmdc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         meta_reg <= RESET_VAL;
         q_out <= RESET_VAL;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end

endmodule

// file: hmdc_top.sv
// host memory decode and DRAM strobe generator with Avalon-MM control registers
// assumes host bus pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module hmdc_top (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // host bus pins
   input wire logic [19:0] host_addr_in,
   input wire logic [2:0] host_bus_status_in,
   input wire logic host_mem_read_n_in,
   input wire logic host_mem_write_n_in,
   input wire logic host_refresh_req_n_in,
   input wire logic supply_monitor_flag_in,
   // memory selects
   output logic boot_rom_select_n_out,
   output logic nv_sram_chip_enable_n_out,
   output logic card_window_enable_n_out,
   output logic card_config_space_n_out,
   output logic card_buffer_enable_out,
   output logic [19:0] card_addr_out,
   output logic slave_sram_select_n_out,
   output logic dsp_port_select_n_out,
   // DRAM control
   output logic dram_op_request_n_out,
   output logic dram_row_strobe_n_out,
   output logic dram_col_strobe_n_out,
   output logic col_addr_select_out,
   output logic [9:0] dram_mux_addr_out,
   output logic dram_write_n_out,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [19:0] addr_s;
   logic [2:0] status_s;
   logic rd_n_s;
   logic wr_n_s;
   logic refresh_n_s;
   logic supply_s;
   logic [5:0] ctl_s;

   hmdc_sync #(.WIDTH(20), .RESET_VAL(20'h00000)) u_sync_addr (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .d_in(host_addr_in),
      .q_out(addr_s)
   );

   // strobes reset to idle so nothing decodes straight after reset
   hmdc_sync #(.WIDTH(6), .RESET_VAL(6'h3F)) u_sync_ctl (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .d_in({host_bus_status_in, host_mem_read_n_in, host_mem_write_n_in, host_refresh_req_n_in}),
      .q_out(ctl_s)
   );

   // power-fail resets to asserted: SRAM stays protected until proven good
   hmdc_sync #(.WIDTH(1), .RESET_VAL(1'h1)) u_sync_pwr (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .d_in(supply_monitor_flag_in),
      .q_out(supply_s)
   );

   assign status_s = ctl_s[5:3];
   assign rd_n_s = ctl_s[2];
   assign wr_n_s = ctl_s[1];
   assign refresh_n_s = ctl_s[0];

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [7:0] card_ctrl_reg;
   logic [1:0] mem_cfg_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic bus_req;
   logic bus_ack;

   assign bus_req = avs_read_in | avs_write_in;
   assign bus_ack = bus_req & ~wait_reg;

   // one wait cycle per access: waitrequest drops on the first edge of a request
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         wait_reg <= 1'b1;
      end else if (bus_req && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   // writes land only on the accepting edge; byte lane 0 carries every field
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         card_ctrl_reg <= hmdc_pkg::CARD_CTRL_RST;
         mem_cfg_reg <= hmdc_pkg::MEM_CFG_RST;
      end else if (bus_ack && avs_write_in && avs_byteenable_in[0]) begin
         if (avs_address_in == hmdc_pkg::CARD_CTRL_OFS) begin
            card_ctrl_reg <= avs_writedata_in[7:0];
         end else if (avs_address_in == hmdc_pkg::MEM_CFG_OFS) begin
            mem_cfg_reg <= avs_writedata_in[1:0];
         end
      end
   end

   hmdc_pkg::hmdc_sel_t sel_q;

   // read data prepared during the wait cycle, unmapped reads return zero
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         rdata_reg <= 32'h00000000;
      end else if (bus_req && wait_reg && avs_read_in) begin
         case (avs_address_in)
            hmdc_pkg::CARD_CTRL_OFS: rdata_reg <= {24'h000000, card_ctrl_reg};
            hmdc_pkg::MEM_CFG_OFS: rdata_reg <= {30'h00000000, mem_cfg_reg};
            hmdc_pkg::STATUS_OFS: rdata_reg <= {25'h0000000, supply_s, sel_q};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end

   assign avs_waitrequest_out = wait_reg;
   assign avs_readdata_out = rdata_reg;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   logic [3:0] card_page;
   logic map_bit;
   logic rom_double;
   logic sram_large;
   logic mem_cycle;
   logic refresh;
   logic sram_ext_hit;
   hmdc_pkg::hmdc_sel_t sel_next;

   assign card_page = card_ctrl_reg[hmdc_pkg::PAGE_LSB +: 4];
   assign map_bit = card_ctrl_reg[hmdc_pkg::MAP_BIT];
   assign rom_double = mem_cfg_reg[hmdc_pkg::ROM_DOUBLE_BIT];
   assign sram_large = mem_cfg_reg[hmdc_pkg::SRAM_LARGE_BIT];

   // a memory cycle needs an active bus status and a strobe
   assign mem_cycle = (status_s != hmdc_pkg::BUS_PASSIVE) && (!rd_n_s || !wr_n_s); // RQ17
   assign refresh = !refresh_n_s; // RQ17
   // extension window only exists with the large part and the map bit set
   assign sram_ext_hit = sram_large && map_bit &&
                         addr_s >= hmdc_pkg::SRAM_EXT_LO && addr_s <= hmdc_pkg::SRAM_EXT_HI;

   // windows overlap only where the SRAM extension masks the doubled ROM, so at most one bit can rise
   always_comb begin
      sel_next = '0; // RQ20
      if (mem_cycle && !refresh) begin // RQ21
         sel_next.rom = (addr_s >= hmdc_pkg::ROM_LO && addr_s <= hmdc_pkg::ROM_HI) || // RQ1
                        (rom_double && !sram_ext_hit && // RQ2 RQ10
                         addr_s >= hmdc_pkg::ROM2_LO && addr_s <= hmdc_pkg::ROM2_HI);
         sel_next.sram = (addr_s >= hmdc_pkg::SRAM_LO && // RQ9
                          addr_s <= (sram_large ? hmdc_pkg::SRAM_LARGE_HI : hmdc_pkg::SRAM_SMALL_HI)) ||
                         sram_ext_hit; // RQ10
         sel_next.card = addr_s >= hmdc_pkg::CARD_LO && addr_s <= hmdc_pkg::CARD_HI; // RQ13
         sel_next.dsp = addr_s >= hmdc_pkg::DSP_LO && addr_s <= hmdc_pkg::DSP_HI; // RQ19
         sel_next.slave = addr_s >= hmdc_pkg::SLAVE_LO && addr_s <= hmdc_pkg::SLAVE_HI; // RQ18
      end
      // DRAM also runs on refresh at addresses up to DRAM_HI so the array keeps its contents
      sel_next.dram = ((mem_cycle && !refresh) || refresh) && addr_s <= hmdc_pkg::DRAM_HI; // RQ3 RQ7
   end

   // ------------------------------------------------------------
   // registered selects
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         sel_q <= '0;
         boot_rom_select_n_out <= 1'b1;
         card_window_enable_n_out <= 1'b1;
         dsp_port_select_n_out <= 1'b1;
         slave_sram_select_n_out <= 1'b1;
      end else begin
         sel_q <= sel_next;
         boot_rom_select_n_out <= !sel_next.rom; // RQ1 RQ2
         card_window_enable_n_out <= !sel_next.card; // RQ13
         dsp_port_select_n_out <= !sel_next.dsp; // RQ19
         slave_sram_select_n_out <= !sel_next.slave; // RQ18
      end
   end

   // SRAM enable gated by power-fail, it must not glitch low while supply collapses
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         nv_sram_chip_enable_n_out <= 1'b1;
      end else begin
         nv_sram_chip_enable_n_out <= !(sel_next.sram && !supply_s); // RQ12
      end
   end

   // card side: page register plus low address, config space and buffers
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         card_addr_out <= 20'h00000;
         card_config_space_n_out <= 1'b1;
         card_buffer_enable_out <= 1'b0;
      end else begin
         card_addr_out <= {card_page, addr_s[15:0]}; // RQ14
         card_config_space_n_out <= !(sel_next.card && !card_ctrl_reg[hmdc_pkg::CFG_N_BIT]); // RQ15
         card_buffer_enable_out <= card_ctrl_reg[hmdc_pkg::BUF_EN_BIT]; // RQ16
      end
   end

   // ------------------------------------------------------------
   // DRAM strobe chain
   // ------------------------------------------------------------
   logic op_n_reg;
   logic row_n_reg;
   logic col_n_reg;
   logic early_row_n;
   logic col_sel_next;

   // early row strobe ends with the request instead of one cycle later
   assign early_row_n = row_n_reg | op_n_reg; // RQ5
   assign col_sel_next = !row_n_reg && !op_n_reg;

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         op_n_reg <= 1'b1;
         row_n_reg <= 1'b1;
         col_n_reg <= 1'b1;
      end else begin
         op_n_reg <= !sel_next.dram; // RQ3
         row_n_reg <= op_n_reg; // RQ4
         col_n_reg <= early_row_n; // RQ5
      end
   end

   // mux moves to column bits once the row strobe is down
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         col_addr_select_out <= 1'b0;
         dram_mux_addr_out <= 10'h000;
         dram_write_n_out <= 1'b1;
      end else begin
         col_addr_select_out <= col_sel_next;
         dram_mux_addr_out <= col_sel_next ? addr_s[19:10] : addr_s[9:0]; // RQ6 RQ7
         dram_write_n_out <= !(sel_next.dram && !refresh && rd_n_s); // RQ8
      end
   end

   assign dram_op_request_n_out = op_n_reg;
   assign dram_row_strobe_n_out = row_n_reg;
   assign dram_col_strobe_n_out = col_n_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   rom_window_a: assert property ( // RQ1
      @(posedge ref_clk_in) disable iff (reset_in)
      (mem_cycle && !refresh && addr_s >= hmdc_pkg::ROM_LO) |=> !boot_rom_select_n_out)
      else $error("rom select missing in rom window");

   dram_request_a: assert property ( // RQ3
      @(posedge ref_clk_in) disable iff (reset_in)
      (mem_cycle && addr_s <= hmdc_pkg::DRAM_HI) |=> !dram_op_request_n_out)
      else $error("dram request missing");

   row_delay_a: assert property ( // RQ4
      @(posedge ref_clk_in) disable iff (reset_in)
      $fell(dram_op_request_n_out) |=> $fell(dram_row_strobe_n_out))
      else $error("row strobe not one cycle after request");

   col_delay_a: assert property ( // RQ5
      @(posedge ref_clk_in) disable iff (reset_in)
      (!dram_row_strobe_n_out && !dram_op_request_n_out) |=> !dram_col_strobe_n_out)
      else $error("column strobe not following row strobe");

   col_abort_a: assert property ( // RQ5
      @(posedge ref_clk_in) disable iff (reset_in)
      dram_op_request_n_out |=> dram_col_strobe_n_out)
      else $error("column strobe not pre-terminated");

   mux_column_a: assert property ( // RQ6
      @(posedge ref_clk_in) disable iff (reset_in)
      col_addr_select_out |-> dram_mux_addr_out == $past(addr_s[19:10]))
      else $error("column address wrong");

   sram_power_a: assert property ( // RQ12
      @(posedge ref_clk_in) disable iff (reset_in)
      supply_s |=> nv_sram_chip_enable_n_out)
      else $error("sram enabled during power down");

   sram_ext_a: assert property ( // RQ10
      @(posedge ref_clk_in) disable iff (reset_in)
      (mem_cycle && !refresh && sram_ext_hit) |=> boot_rom_select_n_out)
      else $error("rom selected over mapped sram");

   select_onehot_a: assert property ( // RQ20
      @(posedge ref_clk_in) disable iff (reset_in)
      $onehot0({!boot_rom_select_n_out, !card_window_enable_n_out, !dsp_port_select_n_out,
                !slave_sram_select_n_out, sel_q.sram, sel_q.dram}))
      else $error("more than one select active");

   refresh_quiet_a: assert property ( // RQ21
      @(posedge ref_clk_in) disable iff (reset_in)
      refresh |=> (boot_rom_select_n_out && card_window_enable_n_out && dsp_port_select_n_out &&
                   slave_sram_select_n_out && nv_sram_chip_enable_n_out))
      else $error("select asserted during refresh");

   card_buffer_a: assert property ( // RQ16
      @(posedge ref_clk_in) disable iff (reset_in)
      card_buffer_enable_out == $past(card_ctrl_reg[hmdc_pkg::BUF_EN_BIT]))
      else $error("card buffer enable does not follow control bit");

endmodule

// file: hmdc_host_model.sv
// host processor bus model driving the decode block's host pins
// assumes the bench raises active_in for the length of one bus cycle
`timescale 1ns/1ps
module hmdc_host_model (
   input wire logic ref_clk_in,
   input wire logic active_in,
   input wire logic [19:0] addr_in,
   input wire logic read_in,
   input wire logic refresh_in,
   output logic [19:0] host_addr_out = 20'h00000,
   output logic [2:0] host_bus_status_out = 3'h7,
   output logic host_mem_read_n_out = 1'h1,
   output logic host_mem_write_n_out = 1'h1,
   output logic host_refresh_req_n_out = 1'h1
);
   // -----------------------------------------------------------
   // bus cycle driver
   // -----------------------------------------------------------
   // pins change only after an edge; between cycles the released
   // address pins toggle so a stale address can never pass for valid
   always @(posedge ref_clk_in) begin
      if (active_in) begin
         host_addr_out <= addr_in;
         host_bus_status_out <= 3'h0;
         host_mem_read_n_out <= ~(read_in | refresh_in);
         host_mem_write_n_out <= read_in | refresh_in;
         host_refresh_req_n_out <= ~refresh_in;
      end else begin
         host_addr_out <= ~host_addr_out;
         host_bus_status_out <= 3'h7;
         host_mem_read_n_out <= 1'h1;
         host_mem_write_n_out <= 1'h1;
         host_refresh_req_n_out <= 1'h1;
      end
   end
endmodule

// file: hmdc_top_tb.sv
// self-checking bench for the host memory decode block
// assumes the host bus model file and the design package are compiled first
`timescale 1ns/1ps
module hmdc_top_tb;
   typedef struct packed {
      logic [19:0] addr;
      logic rd;
      logic [7:0] ctrl;
      logic [1:0] cfg;
      logic [5:0] sel;
   } hmdc_row_t;
   logic ref_clk_in = 1'h0;
   logic reset_in = 1'h1;
   logic supply = 1'h0;
   logic act = 1'h0, m_rd = 1'h0, m_ref = 1'h0;
   logic [19:0] m_addr = 20'h00000, h_addr, card_addr;
   logic [2:0] h_st;
   logic h_rd_n, h_wr_n, h_ref_n, rom_n, sram_n, card_n, cfg_n, buf_en, slave_n, dsp_n;
   logic op_n, row_n, col_n, csel, wr_n, av_wait;
   logic [9:0] mux;
   logic [3:0] av_addr = 4'h0;
   logic av_rd = 1'h0, av_wr = 1'h0;
   logic [31:0] av_wdata = 32'h00000000, av_rdata, q;
   int bad_count = 0, checks_done = 0, op_i, row_i, col_i;
   // ordinary decode cases: address, read, card control, memory config, selects
   hmdc_row_t rows[19] = '{'{20'hC0000, 1'h1, 8'h80, 2'h0, 6'h20},
      '{20'hFFFFF, 1'h0, 8'h80, 2'h0, 6'h20}, '{20'h40000, 1'h1, 8'h80, 2'h0, 6'h00},
      '{20'h40000, 1'h1, 8'h80, 2'h1, 6'h20}, '{20'h7FFFF, 1'h1, 8'h90, 2'h3, 6'h10},
      '{20'h70000, 1'h1, 8'h90, 2'h2, 6'h10}, '{20'h6FFFF, 1'h1, 8'h90, 2'h3, 6'h20},
      '{20'hB7FFF, 1'h1, 8'h80, 2'h0, 6'h10}, '{20'hB8000, 1'h1, 8'h80, 2'h0, 6'h00},
      '{20'hBFFFF, 1'h0, 8'h80, 2'h2, 6'h10}, '{20'h80000, 1'h1, 8'h45, 2'h0, 6'h08},
      '{20'h8FFFF, 1'h0, 8'hCA, 2'h0, 6'h08}, '{20'h90000, 1'h1, 8'h80, 2'h0, 6'h04},
      '{20'h97FFF, 1'h1, 8'h80, 2'h0, 6'h04}, '{20'h98000, 1'h1, 8'h80, 2'h0, 6'h00},
      '{20'hA1FFF, 1'h1, 8'h80, 2'h0, 6'h02}, '{20'hA2000, 1'h1, 8'h80, 2'h0, 6'h00},
      '{20'h3FFFF, 1'h1, 8'h80, 2'h0, 6'h01}, '{20'h00000, 1'h0, 8'h80, 2'h0, 6'h01}};

   always #4 ref_clk_in = ~ref_clk_in;

   hmdc_host_model u_host (.ref_clk_in(ref_clk_in), .active_in(act), .addr_in(m_addr), .read_in(m_rd),
      .refresh_in(m_ref), .host_addr_out(h_addr), .host_bus_status_out(h_st),
      .host_mem_read_n_out(h_rd_n), .host_mem_write_n_out(h_wr_n), .host_refresh_req_n_out(h_ref_n));

   hmdc_top u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .host_addr_in(h_addr),
      .host_bus_status_in(h_st), .host_mem_read_n_in(h_rd_n), .host_mem_write_n_in(h_wr_n),
      .host_refresh_req_n_in(h_ref_n), .supply_monitor_flag_in(supply), .boot_rom_select_n_out(rom_n),
      .nv_sram_chip_enable_n_out(sram_n), .card_window_enable_n_out(card_n),
      .card_config_space_n_out(cfg_n), .card_buffer_enable_out(buf_en), .card_addr_out(card_addr),
      .slave_sram_select_n_out(slave_n), .dsp_port_select_n_out(dsp_n), .dram_op_request_n_out(op_n),
      .dram_row_strobe_n_out(row_n), .dram_col_strobe_n_out(col_n), .col_addr_select_out(csel),
      .dram_mux_addr_out(mux), .dram_write_n_out(wr_n), .avs_address_in(av_addr), .avs_read_in(av_rd),
      .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait));

   // -----------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one Avalon access; waits on waitrequest, never on a fixed count
   // waitrequest and read data are taken at the rising edge that accepts, then released there
   task automatic av(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] r);
      @(posedge ref_clk_in);
      av_addr <= a;
      av_wdata <= {24'h000000, d};
      av_wr <= wr;
      av_rd <= ~wr;
      do begin
         @(posedge ref_clk_in);
      end while (av_wait !== 1'h0);
      r = av_rdata;
      av_wr <= 1'h0;
      av_rd <= 1'h0;
   endtask

   // starts a host cycle and leaves it running with outputs settled
   task automatic cyc(input logic [19:0] a, input logic rd, input logic rf);
      @(posedge ref_clk_in);
      act <= 1'h1;
      m_addr <= a;
      m_rd <= rd;
      m_ref <= rf;
      repeat (6) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask

   task automatic idle();
      @(posedge ref_clk_in);
      act <= 1'h0;
      repeat (8) @(posedge ref_clk_in);
   endtask

   function automatic logic [31:0] sel_now();
      return {26'h0, ~rom_n, ~sram_n, ~card_n, ~dsp_n, ~slave_n, ~op_n};
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // -----------------------------------------------------------
   // watchdog: whole run needs well under 3000 cycles
   // -----------------------------------------------------------
   initial begin
      #200000;
      bad_count++;
      final_report();
   end

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (5) @(posedge ref_clk_in);
      reset_in <= 1'h0;
      av(1'h0, 4'h0, 8'h00, q);
      chk("ctrl reset", 32'h00000080, q);
      av(1'h0, 4'hC, 8'h00, q);
      chk("unmapped read", 32'h00000000, q);
      chk("idle selects", 32'h00000000, sel_now());
      $display("reset test done");
      foreach (rows[i]) begin
         av(1'h1, 4'h0, rows[i].ctrl, q);
         av(1'h1, 4'h4, {6'h00, rows[i].cfg}, q);
         cyc(rows[i].addr, rows[i].rd, 1'h0);
         chk("selects", {26'h0, rows[i].sel}, sel_now());
         chk("buffer enable", {31'h0, rows[i].ctrl[6]}, {31'h0, buf_en});
         if (rows[i].sel[3]) begin
            chk("card addr", {12'h0, rows[i].ctrl[3:0], rows[i].addr[15:0]}, {12'h0, card_addr});
            chk("config space", {31'h0, rows[i].ctrl[7]}, {31'h0, cfg_n});
         end
         if (rows[i].sel[0]) begin
            chk("column addr", {22'h0, rows[i].addr[19:10]}, {22'h0, mux});
            chk("write flag", {31'h0, rows[i].rd}, {31'h0, wr_n});
         end
         idle();
      end
      $display("decode table done");
      // ordinary traffic runs with the map bit clear, as host software keeps it
      av(1'h1, 4'h0, 8'h80, q);
      // strobe order: row one edge after request, column one after row
      cyc(20'h12345, 1'h1, 1'h0);
      idle();
      op_i = -1;
      row_i = -1;
      col_i = -1;
      @(posedge ref_clk_in);
      act <= 1'h1;
      m_addr <= 20'h12345;
      for (int k = 0; k < 10; k++) begin
         @(negedge ref_clk_in);
         if (op_n === 1'h0 && op_i < 0) op_i = k;
         if (row_n === 1'h0 && row_i < 0) row_i = k;
         if (col_n === 1'h0 && col_i < 0) col_i = k;
         if (col_n === 1'h0 && col_i == k) chk("col select", 32'h1, {31'h0, csel});
      end
      chk("row delay", op_i + 1, row_i);
      chk("col delay", op_i + 2, col_i);
      idle();
      $display("strobe test done");
      // refresh at a ROM address must select nothing
      cyc(20'hC0000, 1'h1, 1'h1);
      chk("refresh selects", 32'h0, sel_now() & 32'h3E);
      idle();
      // power-down blocks the SRAM chip enable
      av(1'h1, 4'h4, 8'h00, q);
      supply <= 1'h1;
      cyc(20'hB0000, 1'h1, 1'h0);
      chk("sram blocked", 32'h1, {31'h0, sram_n});
      // status shows the synced supply flag beside the sram select that it gates
      av(1'h0, 4'h8, 8'h00, q);
      chk("status", 32'h00000050, q);
      supply <= 1'h0;
      repeat (5) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("sram enabled", 32'h0, {31'h0, sram_n});
      idle();
      $display("refresh and power test done");
      final_report();
   end
endmodule
